/* dmairq_pkg.sv */
// package: register map, field positions and reset values of the dma interrupt block
package dmairq_pkg;

   // ------------------------------------------------------------------
   // register offsets (byte addresses, low 8 bits decoded)
   // ------------------------------------------------------------------
   localparam logic [31:0] BUF_WORD0_ADDR   = 32'hb000_4080;
   localparam logic [31:0] CTRL_STATUS_ADDR = 32'hb000_40a0;
   localparam int          BUF_WORDS        = 8;
   localparam int          ADDR_W           = 8;

   // ------------------------------------------------------------------
   // field positions of dma_irq_ctrl_status
   // ------------------------------------------------------------------
   localparam int BIT_CH0_DONE_EN  = 0;
   localparam int BIT_CH0_ERR_EN   = 1;
   localparam int BIT_CH1_DONE_EN  = 2;
   localparam int BIT_CH1_ERR_EN   = 3;
   localparam int BIT_CH0_DONE_F   = 8;
   localparam int BIT_CH0_ERR_F    = 9;
   localparam int BIT_CH1_DONE_F   = 10;
   localparam int BIT_CH1_ERR_F    = 11;
   localparam int BIT_SEL_LO       = 16;
   localparam int BIT_SEL_HI       = 17;

   // ------------------------------------------------------------------
   // reset values and view codes
   // ------------------------------------------------------------------
   localparam logic [31:0] CTRL_STATUS_RESET = 32'h0000_0000;
   localparam logic [3:0]  ENABLE_RESET      = 4'h0;
   localparam logic [3:0]  FLAG_RESET        = 4'h0;
   localparam logic [1:0]  SEL_RESET         = 2'h0;
   localparam logic [1:0]  SEL_CH0           = 2'h0;
   localparam logic [1:0]  SEL_CH1           = 2'h1;

endpackage : dmairq_pkg

/* dmairq_flag.sv */
// module: one sticky write-one-to-clear event flag
`timescale 1ns/1ps
module dmairq_flag (
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rstn,
   // set and clear
   input  wire logic i_set,
   input  wire logic i_clear,
   // state
   output logic      o_flag
);

   logic next_flag;

   // set beats clear so an event in the clearing cycle survives
   always_comb begin
      next_flag = o_flag;
      if (i_clear) begin
         next_flag = 1'b0;
      end
      if (i_set) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_flag <= 1'b0;
      end else begin
         o_flag <= next_flag;
      end
   end

endmodule : dmairq_flag

/* dmairq_top.sv */
// module: interrupt control/status and buffer view window of a two-channel dma
// ------------------------------------------------------------------
// How it works
// RULE1 - select 00 shows ch0, 01 ch1
// RULE2 - eight buffer words show selected channel
// RULE3 - ch1 transfer failure sets ch1 error flag
// RULE4 - ch0 transfer failure sets ch0 error flag
// RULE5 - writing one clears error flag
// RULE6 - ch1 done set by hardware, cleared by one
// RULE7 - ch0 done set by hardware, cleared by one
// RULE8 - ch1 done or error feeds interrupt
// RULE9 - ch0 done or error feeds interrupt
// RULE10 - bit 3 enables ch1 error interrupt
// RULE11 - bit 2 enables ch1 done interrupt
// RULE12 - bit 1 enables ch0 error interrupt
// RULE13 - bit 0 enables ch0 done interrupt
// RULE14 - register resets to zero
// RULE15 - interrupt high while enabled flag set
// RULE16 - reserved read zero; set beats clear
// ------------------------------------------------------------------
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module dmairq_top (
   // clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_rstn,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   // channel events, one-cycle pulses from the datapath
   input  wire logic        i_ch0_done,
   input  wire logic        i_ch1_done,
   input  wire logic        i_ch0_error_source,
   input  wire logic        i_ch1_error_source,
   // channel burst buffers, word k at bits [32k+31:32k]
   input  wire logic [255:0] i_ch0_buffer,
   input  wire logic [255:0] i_ch1_buffer,
   // interrupt
   output logic             o_irq
);

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   function automatic logic addr_hit(input logic [7:0] a, input logic [31:0] full);
      addr_hit = (a == full[7:0]);
   endfunction : addr_hit

   function automatic logic in_buffer(input logic [7:0] a);
      in_buffer = (a[7:5] == dmairq_pkg::BUF_WORD0_ADDR[7:5]) && (a[1:0] == 2'h0);
   endfunction : in_buffer

   logic       wr_ctrl;
   logic [3:0] flag_set;
   logic [3:0] flag_clr;
   logic [3:0] flags;

   assign wr_ctrl = i_wr && addr_hit(i_addr, dmairq_pkg::CTRL_STATUS_ADDR);

   // flag order: ch0 done, ch0 error, ch1 done, ch1 error (bits 8..11)
   assign flag_set = {i_ch1_error_source,                               // RULE3
                      i_ch1_done,                                       // RULE6
                      i_ch0_error_source,                               // RULE4
                      i_ch0_done};                                      // RULE7
   assign flag_clr = wr_ctrl ? i_wdata[dmairq_pkg::BIT_CH1_ERR_F:dmairq_pkg::BIT_CH0_DONE_F]
                             : 4'h0;                                    // RULE5

   // ------------------------------------------------------------------
   // sticky flags
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_flag
         dmairq_flag u_flag (
            .i_ref_clk (i_ref_clk),
            .i_rstn    (i_rstn),
            .i_set     (flag_set[gi]),
            .i_clear   (flag_clr[gi]),                                  // RULE16
            .o_flag    (flags[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // control state: enables and buffer view select
   // ------------------------------------------------------------------
   logic [3:0]  enables;
   logic [1:0]  view_sel;
   logic [3:0]  next_enables;
   logic [1:0]  next_view_sel;

   always_comb begin
      next_enables  = enables;
      next_view_sel = view_sel;
      if (wr_ctrl) begin
         next_enables  = i_wdata[dmairq_pkg::BIT_CH1_ERR_EN:dmairq_pkg::BIT_CH0_DONE_EN]; // RULE10 RULE11 RULE12 RULE13
         next_view_sel = i_wdata[dmairq_pkg::BIT_SEL_HI:dmairq_pkg::BIT_SEL_LO];
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         enables  <= dmairq_pkg::ENABLE_RESET;                          // RULE14
         view_sel <= dmairq_pkg::SEL_RESET;                             // RULE14
      end else begin
         enables  <= next_enables;
         view_sel <= next_view_sel;
      end
   end

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   logic [31:0] status_word;
   logic [31:0] buf_word;
   logic [2:0]  word_idx;
   logic [31:0] next_rdata;
   logic        next_irq;

   assign word_idx = i_addr[4:2];

   always_comb begin
      status_word = dmairq_pkg::CTRL_STATUS_RESET;                      // RULE16
      status_word[dmairq_pkg::BIT_CH1_ERR_F:dmairq_pkg::BIT_CH0_DONE_F] = flags;
      status_word[dmairq_pkg::BIT_CH1_ERR_EN:dmairq_pkg::BIT_CH0_DONE_EN] = enables;
      status_word[dmairq_pkg::BIT_SEL_HI:dmairq_pkg::BIT_SEL_LO] = view_sel;
   end

   // reserved select codes read zero rather than alias a channel
   always_comb begin
      unique case (view_sel)
         dmairq_pkg::SEL_CH0: buf_word = i_ch0_buffer[word_idx*32 +: 32]; // RULE1 RULE2
         dmairq_pkg::SEL_CH1: buf_word = i_ch1_buffer[word_idx*32 +: 32]; // RULE1 RULE2
         default:             buf_word = 32'h0000_0000;
      endcase
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (i_rd) begin
         if (addr_hit(i_addr, dmairq_pkg::CTRL_STATUS_ADDR)) begin
            next_rdata = status_word;
         end else if (in_buffer(i_addr)) begin
            next_rdata = buf_word;
         end
      end
   end

   // per-channel sources ored into one line
   always_comb begin
      next_irq = |(flags[1:0] & enables[1:0])                           // RULE9
               | |(flags[3:2] & enables[3:2]);                          // RULE8 RULE15
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rstn) begin
         o_rdata <= 32'h0000_0000;
         o_irq   <= 1'b0;
      end else begin
         o_rdata <= next_rdata;
         o_irq   <= next_irq;
      end
   end

endmodule : dmairq_top

/* dmairq_checker.sv */
// checker: bus, view and interrupt properties of the dma interrupt block
`timescale 1ns/1ps
module dmairq_checker (
   // clock and reset
   input wire logic         i_ref_clk,
   input wire logic         i_rstn,
   // register port
   input wire logic [7:0]   i_addr,
   input wire logic [31:0]  i_wdata,
   input wire logic         i_wr,
   input wire logic         i_rd,
   input wire logic [31:0]  o_rdata,
   // events, buffers, interrupt
   input wire logic         i_ch0_done,
   input wire logic         i_ch1_done,
   input wire logic         i_ch0_error_source,
   input wire logic         i_ch1_error_source,
   input wire logic [255:0] i_ch0_buffer,
   input wire logic [255:0] i_ch1_buffer,
   input wire logic         o_irq
);
   // shadow of enables and select, flags are not visible here
   logic [3:0] en;
   logic [1:0] sel;
   wire        quiet = !(i_ch0_done | i_ch1_done | i_ch0_error_source | i_ch1_error_source);
   always_ff @(posedge i_ref_clk)
      if (!i_rstn) {sel, en} <= 6'h00;
      else if (i_wr && i_addr == 8'ha0) {sel, en} <= {i_wdata[17:16], i_wdata[3:0]};
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_ev(ev, ok); ev && ok && !i_wr ##1 !i_wr; endsequence
   sequence s_clr; i_wr && i_addr == 8'ha0 && i_wdata[11:8] == 4'hf && quiet; endsequence
   property p_rsv; $past(i_rd && i_addr == 8'ha0) |-> (o_rdata & 32'hfffc_f0f0) == 32'h0000_0000; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_back; $past(i_rd && i_addr == 8'ha0) |-> o_rdata[17:16] == $past(sel) && o_rdata[3:0] == $past(en); endproperty
   a_back: assert property (p_back) else $error("enable readback wrong");
   property p_buf0; $past(i_rd && i_addr == 8'h80 && sel == 2'h0) |-> o_rdata == $past(i_ch0_buffer[31:0]); endproperty
   a_buf0: assert property (p_buf0) else $error("ch0 view wrong");
   property p_buf1; $past(i_rd && i_addr == 8'h9c && sel == 2'h1) |-> o_rdata == $past(i_ch1_buffer[255:224]); endproperty
   a_buf1: assert property (p_buf1) else $error("ch1 view wrong");
   property p_unm; $past(i_rd && i_addr > 8'ha0) |-> o_rdata == 32'h0000_0000; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_d0; s_ev(i_ch0_done, en[0]) |-> ##1 o_irq; endproperty
   a_d0: assert property (p_d0) else $error("ch0 done irq missing");
   property p_e1; s_ev(i_ch1_error_source, en[3]) |-> ##1 o_irq; endproperty
   a_e1: assert property (p_e1) else $error("ch1 error irq missing");
   property p_mask; (en == 4'h0) [*2] |=> !o_irq; endproperty
   a_mask: assert property (p_mask) else $error("masked irq high");
   property p_clr; s_clr |-> ##2 !o_irq; endproperty
   a_clr: assert property (p_clr) else $error("irq after clear");
endmodule : dmairq_checker
bind dmairq_top dmairq_checker chk_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ch0_done(i_ch0_done), .i_ch1_done(i_ch1_done),
   .i_ch0_error_source(i_ch0_error_source), .i_ch1_error_source(i_ch1_error_source),
   .i_ch0_buffer(i_ch0_buffer), .i_ch1_buffer(i_ch1_buffer), .o_irq(o_irq));

/* tb_dmairq_top.sv */
// testbench: random and corner traffic for the dma interrupt block
`timescale 1ns/1ps
module tb_dmairq_top;
   logic         clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, o_irq;
   logic [7:0]   a = 8'h00;
   logic [31:0]  d = 32'h0000_0000, r, w, o_rdata;
   logic [3:0]   ev = 4'h0, f = 4'h0, e, e2;
   logic [255:0] b0 = '0, b1 = '0;
   int           mismatches = 0, check_count = 0, k;
   always #50 clk = ~clk;
   dmairq_top uut (.i_ref_clk(clk), .i_rstn(rstn), .i_addr(a), .i_wdata(d), .i_wr(wr), .i_rd(rd),
      .o_rdata(o_rdata), .i_ch0_done(ev[0]), .i_ch1_done(ev[2]), .i_ch0_error_source(ev[1]),
      .i_ch1_error_source(ev[3]), .i_ch0_buffer(b0), .i_ch1_buffer(b1), .o_irq(o_irq));
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         mismatches++;
         $display("mismatch at %0t: got %h, expected %h", $time, s, x);
      end
   endtask : chk
   task automatic cyc(input logic w_, input logic r_, input logic [7:0] a_, input logic [31:0] d_,
                      input logic [3:0] e_);
      @(posedge clk);
      {wr, rd, a, d, ev} <= {w_, r_, a_, d_, e_};
   endtask : cyc
   // read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a_, input logic [31:0] x);
      cyc(1'b0, 1'b1, a_, 32'h0000_0000, 4'h0);
      cyc(1'b0, 1'b0, a_, 32'h0000_0000, 4'h0);
      #1 chk(o_rdata, x);
   endtask : rdchk
   function automatic logic [31:0] view(input logic [1:0] s, input int n);
      return (s == 2'h0) ? b0[32*n+:32] : (s == 2'h1) ? b1[32*n+:32] : 32'h0000_0000;
   endfunction : view
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #2_000_000;
      mismatches++;
      wrap_up();
   end
   initial begin
      void'($urandom(93530));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rdchk(8'ha0, 32'h0000_0000);
      repeat (300) begin
         {e, e2, w, k} = {4'($urandom), 4'($urandom), $urandom, $urandom_range(7, 0)};
         // corner: full clear of all flags with no event beside it
         if (w[0] & w[4]) {w[11:8], e2} = 8'hf0;
         cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000, e);
         for (int j = 0; j < 8; j++) {b0[32*j+:32], b1[32*j+:32]} <= {$urandom, $urandom};
         cyc(1'b0, 1'b0, 8'h00, 32'h0000_0000, 4'h0);
         cyc(1'b1, 1'b0, 8'ha0, w, e2);
         f = ((f | e) & ~w[11:8]) | e2;
         r = w & 32'h0003_000f;
         rdchk(8'ha0, r | {20'h0_0000, f, 8'h00});
         chk(o_irq, |(f & r[3:0]));
         rdchk(8'h80 + 8'(4 * k), view(r[17:16], k));
         cyc(1'b1, 1'b0, 8'h80 + 8'(4 * k), ~w, 4'h0);
         rdchk(8'ha4 + 8'(4 * k), 32'h0000_0000);
      end
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rdchk(8'ha0, 32'h0000_0000);
      chk(o_irq, 1'b0);
      wrap_up();
   end
endmodule : tb_dmairq_top
